// file: rtl/plm_regs.svh
// What this block does
// (R1) Register pointer advances by one while each data byte is acknowledged.
// (R2) Advancing repeats for every further data byte of a write transfer.
// (R3) Function page registers except 04h return their contents when read; frame pages only as in (R4).
// (R4) Frame pages read back only in software shutdown with shutdown pin high.
// (R5) Function page reads back in shutdown and in normal operation.
// (R6) Host starts a read with address write, location FDh, then page code.
// (R7) After restart host sends address write and the register location.
// (R8) After another restart host reads; device returns the selected register.
// (R9) Page codes 00h to 07h select frame pages one to eight.
// (R10) Page code 0Bh selects the function page; others are reserved.
// (R11) Page select comes first; data goes to the selected page until changed.
// (R12) Locations start at 00h in every page; frame pages share one layout.
// (R13) Frame page: on/off 00h-11h, blink 12h-23h, duty 24h-B3h, all read/write.
// (R14) Function page read/write at 00h-0Ch, frame state at 07h read-only.
// (R15) Frame contents undefined at power-up; the host initialises them.
// (R16) Location 04h takes writes with no effect; it reads back as 00h.
// (R17) Each on/off bit drives one LED: 1 on, 0 off.
// (R18) Each blink bit configures one LED, same ordering as on/off bits.
// (R19) Shutdown register at 0Ah places the device into software shutdown.
// (R20) Bus address is 11101 plus two bits from the address-select strap.
// (R21) Device acknowledges location and data bytes by pulling data low.
// (R22) Reserved page codes ignored; frame reads outside shutdown return 00h.
`ifndef PLM_REGS_SVH
`define PLM_REGS_SVH

`define PLM_DEV_ADDR_HI     5'h1D
`define PLM_PAGE_SEL_LOC    8'hFD
`define PLM_LAST_FRAME_CODE 8'h07
`define PLM_FUNC_PAGE_CODE  8'h0B
`define PLM_PAGE_RST        8'h00

`define PLM_ONOFF_BASE      8'h00
`define PLM_BLINK_BASE      8'h12
`define PLM_DUTY_BASE       8'h24
`define PLM_FRAME_LAST      8'hB3
`define PLM_FRAME_BYTES     11'h0B4

`define PLM_OPER_CFG        8'h00
`define PLM_PIC_FRAME       8'h01
`define PLM_AUTOPLAY_ONE    8'h02
`define PLM_AUTOPLAY_DELAY  8'h03
`define PLM_RSVD_SLOT       8'h04
`define PLM_DISP_OPTION     8'h05
`define PLM_AUDIO_SYNC      8'h06
`define PLM_FRAME_STATE     8'h07
`define PLM_BREATH_TIMING   8'h08
`define PLM_BREATH_ENABLE   8'h09
`define PLM_SW_SHUTDOWN     8'h0A
`define PLM_AGC_CTRL        8'h0B
`define PLM_AUDIO_RATE      8'h0C
`define PLM_FUNC_LAST       8'h0C

`define PLM_SHUT_RUN_BIT    0
`define PLM_FUNC_RST        8'h00
`define PLM_READ_FILL       8'h00

`endif

// file: rtl/plm_pkg.sv
package plm_pkg;

    typedef enum logic [2:0] {
        PLM_IDLE,
        PLM_ADDR,
        PLM_ACK_ADDR,
        PLM_RECV,
        PLM_ACK_DATA,
        PLM_SEND,
        PLM_HOST_ACK
    } plm_i2c_st_t;

    typedef struct packed {
        logic              scl_m;
        logic              scl_s;
        logic              scl_d;
        logic              sda_m;
        logic              sda_s;
        logic              sda_d;
        logic              pin_m;
        logic              pin_s;
        logic [1:0]        ad_m;
        logic [1:0]        ad_s;
        plm_i2c_st_t       st;
        logic [3:0]        bcnt;
        logic [7:0]        shreg;
        logic [7:0]        ptr;
        logic [7:0]        page;
        logic              first;
        logic              rw;
        logic              nack;
        logic              sda_oe;
        logic              sda_lo;
        logic              shut;
        logic [12:0][7:0]  func;
    } plm_state_t;

endpackage

// file: rtl/plm_top.sv
`timescale 1ns/10ps
`include "plm_regs.svh"

module plm_top
    import plm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic [1:0]  ad_sel,
    input  wire logic        shutdown_pin,
    output logic             sw_shutdown
);

    plm_state_t  q_r;
    plm_state_t  q_nxt;
    logic        mem_we;
    logic [7:0]  rd_byte;
    logic [10:0] mem_idx;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;
    logic        frame_rd_ok;
    logic        page_is_func;
    logic        func_hit;

    // frame storage, no reset: contents undefined until host fills it
    logic [7:0]  frame_mem [0:1439];  // see (R15)

    // identical layout per frame page, base of page n is n*180
    assign mem_idx = 11'(q_r.page[2:0] * `PLM_FRAME_BYTES) + {3'h0, q_r.ptr};  // see (R12)

    assign scl_rise  = q_r.scl_s & ~q_r.scl_d;
    assign scl_fall  = ~q_r.scl_s & q_r.scl_d;
    assign bus_start = q_r.scl_s & q_r.scl_d & q_r.sda_d & ~q_r.sda_s;
    assign bus_stop  = q_r.scl_s & q_r.scl_d & ~q_r.sda_d & q_r.sda_s;

    assign page_is_func = (q_r.page == `PLM_FUNC_PAGE_CODE);
    assign func_hit     = (q_r.ptr <= `PLM_FUNC_LAST);
    // software shutdown and pin high both needed for frame readback
    assign frame_rd_ok  = q_r.shut & q_r.pin_s;  // see (R4)

    always_comb begin
        rd_byte = `PLM_READ_FILL;
        if (q_r.ptr == `PLM_PAGE_SEL_LOC) begin
            rd_byte = q_r.page;
        end else if (page_is_func) begin
            // function page readable in any mode
            if (func_hit && q_r.ptr != `PLM_RSVD_SLOT) begin
                rd_byte = q_r.func[q_r.ptr[3:0]];  // see (R5) see (R14) see (R16)
            end
        end else if (q_r.ptr <= `PLM_FRAME_LAST && frame_rd_ok) begin
            // on/off, blink and duty banks share one array
            rd_byte = frame_mem[mem_idx];  // see (R3) see (R13) see (R22)
        end
    end

    always_comb begin
        q_nxt        = q_r;
        mem_we       = 1'b0;
        q_nxt.scl_m  = scl_i;
        q_nxt.scl_s  = q_r.scl_m;
        q_nxt.scl_d  = q_r.scl_s;
        q_nxt.sda_m  = sda_i;
        q_nxt.sda_s  = q_r.sda_m;
        q_nxt.sda_d  = q_r.sda_s;
        q_nxt.pin_m  = shutdown_pin;
        q_nxt.pin_s  = q_r.pin_m;
        q_nxt.ad_m   = ad_sel;
        q_nxt.ad_s   = q_r.ad_m;
        q_nxt.sda_lo = 1'b0;
        // run bit low means software shutdown
        q_nxt.shut   = ~q_r.func[`PLM_SW_SHUTDOWN][`PLM_SHUT_RUN_BIT];  // see (R19)

        if (bus_start) begin
            q_nxt.st     = PLM_ADDR;
            q_nxt.bcnt   = 4'h0;
            q_nxt.sda_oe = 1'b0;
            q_nxt.first  = 1'b1;
        end else if (bus_stop) begin
            q_nxt.st     = PLM_IDLE;
            q_nxt.sda_oe = 1'b0;
        end else begin
            case (q_r.st)
                PLM_IDLE: begin
                    q_nxt.sda_oe = 1'b0;
                end
                PLM_ADDR: begin
                    if (scl_rise) begin
                        q_nxt.shreg = {q_r.shreg[6:0], q_r.sda_s};
                        q_nxt.bcnt  = q_r.bcnt + 4'h1;
                    end else if (scl_fall && q_r.bcnt == 4'h8) begin
                        if (q_r.shreg[7:1] == {`PLM_DEV_ADDR_HI, q_r.ad_s}) begin  // see (R20)
                            q_nxt.sda_oe = 1'b1;
                            q_nxt.rw     = q_r.shreg[0];
                            q_nxt.st     = PLM_ACK_ADDR;
                        end else begin
                            q_nxt.st = PLM_IDLE;
                        end
                    end
                end
                PLM_ACK_ADDR: begin
                    if (scl_fall) begin
                        q_nxt.bcnt = 4'h0;
                        if (q_r.rw) begin
                            // read returns location set by prior write phase
                            q_nxt.shreg  = rd_byte;  // see (R8)
                            q_nxt.sda_oe = ~rd_byte[7];
                            q_nxt.st     = PLM_SEND;
                        end else begin
                            q_nxt.sda_oe = 1'b0;
                            q_nxt.st     = PLM_RECV;
                        end
                    end
                end
                PLM_RECV: begin
                    if (scl_rise) begin
                        q_nxt.shreg = {q_r.shreg[6:0], q_r.sda_s};
                        q_nxt.bcnt  = q_r.bcnt + 4'h1;
                    end else if (scl_fall && q_r.bcnt == 4'h8) begin
                        q_nxt.sda_oe = 1'b1;  // see (R21)
                        q_nxt.st     = PLM_ACK_DATA;
                        if (q_r.first) begin
                            // first byte after address is the location
                            q_nxt.ptr   = q_r.shreg;  // see (R7) see (R12)
                            q_nxt.first = 1'b0;
                        end else begin
                            q_nxt.ptr = q_r.ptr + 8'h01;  // see (R1) see (R2)
                            if (q_r.ptr == `PLM_PAGE_SEL_LOC) begin
                                if (q_r.shreg <= `PLM_LAST_FRAME_CODE ||
                                    q_r.shreg == `PLM_FUNC_PAGE_CODE) begin
                                    q_nxt.page = q_r.shreg;  // see (R6) see (R9) see (R10) see (R11)
                                end
                            end else if (page_is_func) begin
                                if (func_hit && q_r.ptr != `PLM_FRAME_STATE &&
                                    q_r.ptr != `PLM_RSVD_SLOT) begin
                                    q_nxt.func[q_r.ptr[3:0]] = q_r.shreg;  // see (R14) see (R16)
                                end
                            end else if (q_r.ptr <= `PLM_FRAME_LAST) begin
                                // one bit per LED for on/off and blink banks
                                mem_we = 1'b1;  // see (R13) see (R17) see (R18)
                            end
                        end
                    end
                end
                PLM_ACK_DATA: begin
                    if (scl_fall) begin
                        q_nxt.sda_oe = 1'b0;
                        q_nxt.bcnt   = 4'h0;
                        q_nxt.st     = PLM_RECV;
                    end
                end
                PLM_SEND: begin
                    if (scl_rise) begin
                        q_nxt.bcnt = q_r.bcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q_r.bcnt == 4'h8) begin
                            q_nxt.sda_oe = 1'b0;
                            q_nxt.ptr    = q_r.ptr + 8'h01;
                            q_nxt.st     = PLM_HOST_ACK;
                        end else begin
                            q_nxt.shreg  = {q_r.shreg[6:0], 1'b0};
                            q_nxt.sda_oe = ~q_r.shreg[6];
                        end
                    end
                end
                PLM_HOST_ACK: begin
                    if (scl_rise) begin
                        q_nxt.nack = q_r.sda_s;
                    end else if (scl_fall) begin
                        q_nxt.bcnt = 4'h0;
                        if (q_r.nack) begin
                            q_nxt.st = PLM_IDLE;
                        end else begin
                            q_nxt.shreg  = rd_byte;  // see (R3)
                            q_nxt.sda_oe = ~rd_byte[7];
                            q_nxt.st     = PLM_SEND;
                        end
                    end
                end
                default: begin
                    q_nxt.st     = PLM_IDLE;
                    q_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q_r       <= '0;
            q_r.scl_m <= 1'b1;
            q_r.scl_s <= 1'b1;
            q_r.scl_d <= 1'b1;
            q_r.sda_m <= 1'b1;
            q_r.sda_s <= 1'b1;
            q_r.sda_d <= 1'b1;
            q_r.st    <= PLM_IDLE;
            q_r.page  <= `PLM_PAGE_RST;
            q_r.shut  <= 1'b1;
            q_r.func  <= {13{`PLM_FUNC_RST}};
        end else begin
            q_r <= q_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (mem_we) begin
            frame_mem[mem_idx] <= q_r.shreg;
        end
    end

    assign sda_o       = q_r.sda_lo;
    assign sda_oe      = q_r.sda_oe;
    assign sw_shutdown = q_r.shut;

endmodule // plm_top

// file: test/plm_assertions.sv
`timescale 1ns/10ps
module plm_assertions
    import plm_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic [1:0] ad_sel,
    input wire logic       shutdown_pin,
    input wire logic       sw_shutdown
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_low_settled;
        !scl_i && !$past(scl_i);
    endsequence
    sequence s_oe_held;
        sda_oe [*8];
    endsequence
    AST_DRIVE_ZERO: assert property (sda_o == 1'b0)
        else $error("sda drive value not zero");
    AST_RESET_STATE: assert property ($rose(rst_n) |-> sw_shutdown && !sda_oe)
        else $error("bad state after reset");
    AST_OE_RISE_LOW: assert property ($rose(sda_oe) |-> s_low_settled)
        else $error("sda pulled while scl high");
    AST_OE_FALL_LOW: assert property ($fell(sda_oe) |-> !scl_i)
        else $error("sda released while scl high");
    AST_OE_HOLD: assert property ($rose(scl_i) && sda_oe |-> s_oe_held)
        else $error("sda pull dropped early");
    AST_OE_STABLE: assert property (scl_i && $past(scl_i, 4) |-> $stable(sda_oe))
        else $error("sda drive moved in scl high");
    AST_NO_START: assert property ($fell(sda_i) && scl_i |-> !sda_oe)
        else $error("device made a start");
    AST_SHUT_ON_BYTE: assert property ($changed(sw_shutdown) |-> !scl_i)
        else $error("shutdown moved off a byte end");
    AST_PIN_NOT_REG: assert property ($changed(shutdown_pin) |=> $stable(sw_shutdown))
        else $error("pin altered shutdown register");
endmodule // plm_assertions

// file: test/plm_host.sv
`timescale 1ns/10ps
module plm_host (
    input  wire logic mclk,
    input  wire logic sda_w,
    output logic      scl,
    output logic      sda_m
);
    logic [6:0] dev = {5'h1D, 2'b10};
    int         nak = 0;
    int         lo = 65;
    initial begin
        scl <= 1'b1;
        sda_m <= 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic xbit(input logic b, output logic r);
        tick(lo);
        sda_m <= b;
        tick(lo);
        scl <= 1'b1;
        tick(35);
        r = sda_w;
        tick(35);
        scl <= 1'b0;
    endtask
    // start setup and hold and stop setup kept at 0.6 us
    task automatic start;
        sda_m <= 1'b1;
        tick(lo);
        scl <= 1'b1;
        tick(60);
        sda_m <= 1'b0;
        tick(60);
        scl <= 1'b0;
    endtask
    task automatic stop;
        tick(lo);
        sda_m <= 1'b0;
        tick(lo);
        scl <= 1'b1;
        tick(60);
        sda_m <= 1'b1;
        tick(35);
    endtask
    task automatic put(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        if (r !== 1'b0) nak++;
    endtask
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(last, r);
    endtask
    // page choice first, then location after a restart
    task automatic sel(input logic [7:0] pg, input logic [7:0] loc);
        start;
        put({dev, 1'b0});
        put(8'hFD);
        put(pg);
        start;
        put({dev, 1'b0});
        put(loc);
    endtask
    task automatic wr(input logic [7:0] pg, input logic [7:0] loc, input logic [7:0] d[$]);
        sel(pg, loc);
        foreach (d[i]) put(d[i]);
        stop;
    endtask
    task automatic rd(input logic [7:0] pg, input logic [7:0] loc, input int n, output logic [7:0] q[$]);
        logic [7:0] b;
        sel(pg, loc);
        start;
        put({dev, 1'b1});
        q = {};
        for (int i = 0; i < n; i++) begin
            get(i == n - 1, b);
            q.push_back(b);
        end
        stop;
    endtask
endmodule // plm_host

// file: test/paged_led_matrix_register_access_bench.sv
`timescale 1ns/10ps
module paged_led_matrix_register_access_bench
    import plm_pkg::*;
;
    logic       mclk;
    logic       rst_n;
    logic       scl;
    logic       sda_m;
    logic       sda_o;
    logic       sda_oe;
    logic [1:0] ad_sel;
    logic       shutdown_pin;
    logic       sw_shutdown;
    wire        sda_w;
    int         miscompares = 0;
    int         tests_run = 0;
    logic [7:0] rq[$];
    // open drain wire with pull-up
    assign sda_w = sda_m & ~(sda_oe & ~sda_o);
    plm_top dut_u (.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .ad_sel(ad_sel), .shutdown_pin(shutdown_pin), .sw_shutdown(sw_shutdown));
    plm_host host_u (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] pg, input logic [7:0] loc, input logic [7:0] exp[$]);
        host_u.rd(pg, loc, exp.size(), rq);
        foreach (exp[i]) check(rq[i], exp[i]);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        // clean run takes about 98k cycles
        repeat (100000) @(posedge mclk);
        miscompares++;
        $display("ERROR %0t: watchdog expired", $time);
        test_done;
    end
    initial begin
        rst_n <= 1'b0;
        ad_sel <= 2'b10;
        shutdown_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        check({7'h00, sw_shutdown}, 8'h01);
        host_u.wr(8'h07, 8'h11, '{8'hA5, 8'h5A, 8'hC3});
        host_u.wr(8'h0C, 8'h14, '{8'h77});
        rdchk(8'h07, 8'h11, '{8'hA5, 8'h5A, 8'hC3, 8'h77});
        $display("frame burst test done");
        shutdown_pin <= 1'b0;
        rdchk(8'h00, 8'h11, '{8'h00});
        shutdown_pin <= 1'b1;
        $display("frame guard test done");
        host_u.wr(8'h0B, 8'h07, '{8'hFF, 8'h33, 8'h44, 8'h01});
        check({7'h00, sw_shutdown}, 8'h00);
        rdchk(8'h0B, 8'h07, '{8'h00, 8'h33, 8'h44, 8'h01});
        check(host_u.nak[7:0], 8'h00);
        $display("function page test done");
        // slow host, strap mismatch in the low address bits
        host_u.lo = 130;
        host_u.start;
        host_u.put(8'hEA);
        host_u.stop;
        check(host_u.nak[7:0], 8'h01);
        $display("address test done");
        test_done;
    end
endmodule // paged_led_matrix_register_access_bench

bind plm_top plm_assertions chk_u (.mclk(mclk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .ad_sel(ad_sel), .shutdown_pin(shutdown_pin), .sw_shutdown(sw_shutdown));
